/* File: rtl/aisc_cfg.svh */
// Constants for the analog input scaling curve block.
// Assumes a 125 MHz system clock and values in units of 0.00001.
`ifndef AISC_CFG_SVH
`define AISC_CFG_SVH
`define AISC_VW 48
`define AISC_NUM_CURVES 10
`define AISC_NUM_MA 8
`define AISC_NUM_DI 20
`define AISC_NUM_RTD 16
`define AISC_SEL_W 6
`define AISC_UPD_W 16
`define AISC_TC_W 20
`define AISC_SLOPE_W 32
`define AISC_SLOPE_FRAC 16
`define AISC_CLK_MHZ 125
`define AISC_STEP_US 5000
`define AISC_STEP_CYCLES (`AISC_STEP_US * `AISC_CLK_MHZ)
`define AISC_UPD_DEF_MS 150
`define AISC_UPD_DEF_STEPS (`AISC_UPD_DEF_MS * 1000 / `AISC_STEP_US)
`define AISC_TC_DEF_MS 1000
`define AISC_TC_DEF_STEPS (`AISC_TC_DEF_MS * 1000 / `AISC_STEP_US)
`define AISC_MIN_DEF 48'h000000000000
`define AISC_MAX_DEF 48'h000000000000
`define AISC_SEL_DEF 6'h00
`define AISC_DIV_BITS 65
`endif

/* File: rtl/aisc_filt_if.sv */
// Carrier between the curve sequencer and one averaging filter.
// Assumes both ends sit on sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
interface aisc_filt_if;
	logic start;
	logic enable;
	logic [`AISC_VW-1:0] sample;
	logic [`AISC_UPD_W-1:0] updSteps;
	logic [`AISC_TC_W-1:0] tcSteps;
	logic done;
	logic [`AISC_VW-1:0] result;
	modport ctrl (output start, output enable, output sample, output updSteps,
		output tcSteps, input done, input result);
	modport filt (input start, input enable, input sample, input updSteps,
		input tcSteps, output done, output result);
endinterface : aisc_filt_if
`default_nettype wire

/* File: rtl/aisc_filter.sv */
// First-order averaging stage, one per curve, stepped once per update.
// Assumes starts are spaced far more than 70 cycles apart.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
module aisc_filter
	import aisc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	aisc_filt_if.filt fif
);
	aisc_filt_state_t st_reg;
	aisc_filt_state_t st_next;
	logic signed [`AISC_VW:0] diff;
	logic [`AISC_VW:0] mag;
	logic [`AISC_TC_W:0] remSh;

	assign fif.done = st_reg.done;
	assign fif.result = st_reg.y;

	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		diff = $signed({fif.sample[`AISC_VW-1], fif.sample}) - $signed({st_reg.y[`AISC_VW-1], st_reg.y});
		mag = diff[`AISC_VW] ? (`AISC_VW+1)'(-diff) : diff;
		remSh = {st_reg.rem[`AISC_TC_W-1:0], st_reg.num[`AISC_DIV_BITS-1]};
		unique case (st_reg.state)
			AISC_F_IDLE:
			begin
				if (fif.start)
				begin
					// Step y += (x - y) * dt / tau, dt being the update cycle
					if (!st_reg.primed || fif.tcSteps == '0
						|| {4'h0, fif.updSteps} >= fif.tcSteps)
					begin
						st_next.y = fif.sample;
						st_next.primed = 1'b1;
						st_next.done = 1'b1;
					end
					else
					begin
						st_next.neg = diff[`AISC_VW];
						st_next.num = `AISC_DIV_BITS'(mag) * `AISC_DIV_BITS'(fif.updSteps);
						st_next.rem = '0;
						st_next.quo = '0;
						st_next.bitCnt = '0;
						st_next.state = AISC_F_DIVIDE;
					end
				end
			end
			AISC_F_DIVIDE:
			begin
				// Serial divide; the update cycle leaves ample time
				st_next.num = {st_reg.num[`AISC_DIV_BITS-2:0], 1'b0};
				if (remSh >= {1'b0, fif.tcSteps})
				begin
					st_next.rem = remSh - {1'b0, fif.tcSteps};
					st_next.quo = {st_reg.quo[`AISC_DIV_BITS-2:0], 1'b1};
				end
				else
				begin
					st_next.rem = remSh;
					st_next.quo = {st_reg.quo[`AISC_DIV_BITS-2:0], 1'b0};
				end
				st_next.bitCnt = st_reg.bitCnt + 7'h01;
				if (st_reg.bitCnt == 7'(`AISC_DIV_BITS-1))
					st_next.state = AISC_F_APPLY;
			end
			AISC_F_APPLY:
			begin
				st_next.y = st_reg.neg ? st_reg.y - st_reg.quo[`AISC_VW-1:0]
					: st_reg.y + st_reg.quo[`AISC_VW-1:0];
				st_next.done = 1'b1;
				st_next.state = AISC_F_IDLE;
			end
			default:
				st_next.state = AISC_F_IDLE;
		endcase
		// Re-enabling starts from the raw value, not a stale average
		if (!fif.enable)
		begin
			st_next.primed = 1'b0;
			st_next.state = AISC_F_IDLE;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			st_reg <= '{state: AISC_F_IDLE, default: '0};
		else
			st_reg <= st_next;
	end
endmodule : aisc_filter
`default_nettype wire

/* File: rtl/aisc_pkg.sv */
// Types shared by the scaling curve top and its filter.
// Assumes aisc_cfg.svh is on the include path.
`include "aisc_cfg.svh"
package aisc_pkg;
	typedef logic signed [`AISC_VW-1:0] aisc_val_t;
	typedef enum logic [1:0] {
		AISC_F_IDLE = 2'b00,
		AISC_F_DIVIDE = 2'b01,
		AISC_F_APPLY = 2'b10
	} aisc_filt_e_t;
	typedef struct packed {
		aisc_filt_e_t state;
		logic primed;
		logic neg;
		logic done;
		logic [6:0] bitCnt;
		logic [`AISC_TC_W:0] rem;
		logic [`AISC_DIV_BITS-1:0] num;
		logic [`AISC_DIV_BITS-1:0] quo;
		aisc_val_t y;
	} aisc_filt_state_t;
endpackage : aisc_pkg

/* File: rtl/aisc_top.sv */
// Analog input scaling curves: source select, averaging, mapping, range alarm.
// Assumes settings ports are held by software and sources are synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
// How it works
// - Master scaling enable gates every curve; when off, no curve is updated, though updateStrobe still pulses.
// - Per-curve enable gates acquisition and computation of that curve.
// - Each curve selects a current loop, binary input voltage or sensor source.
// - Selector codes beyond the supported sources acquire nothing.
// - With filtering on, the averaged value replaces the raw input.
// - Time constant is set in 5 ms steps and used only while filtering.
// - Range supervision per curve raises the alarm outside min and max.
// - Input below the minimum limit raises the range alarm.
// - Input above the maximum limit raises the range alarm.
// - Present curve input is shown per curve.
// - Present computed curve output is shown per curve.
// - Filter is a first-order low-pass stepped each update cycle.
// - A lost source holds the last measured value.
// - Inputs are re-measured once per update cycle, set in 5 ms steps.
// - Output maps input linearly through a slope and offset.
module aisc_top
	import aisc_pkg::*;
#(
	parameter int NUM_CURVES = `AISC_NUM_CURVES,
	parameter int NUM_MA = `AISC_NUM_MA,
	parameter int NUM_DI = `AISC_NUM_DI,
	parameter int NUM_RTD = `AISC_NUM_RTD,
	parameter int STEP_CYCLES = `AISC_STEP_CYCLES
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scalingEnable,
	input wire logic [NUM_CURVES-1:0] curveEnable,
	input wire logic [NUM_CURVES-1:0][`AISC_SEL_W-1:0] curveSourceSelect,
	input wire logic [NUM_CURVES-1:0] filterEnable,
	input wire logic [NUM_CURVES-1:0][`AISC_TC_W-1:0] filterTimeSteps,
	input wire logic [`AISC_UPD_W-1:0] updateCycleSteps,
	input wire logic [NUM_CURVES-1:0] rangeSupervisionEnable,
	input wire logic [NUM_CURVES-1:0][`AISC_VW-1:0] inputMinimum,
	input wire logic [NUM_CURVES-1:0][`AISC_VW-1:0] inputMaximum,
	input wire logic [NUM_CURVES-1:0][`AISC_SLOPE_W-1:0] curveSlope,
	input wire logic [NUM_CURVES-1:0][`AISC_VW-1:0] curveOffset,
	input wire logic [NUM_MA-1:0][`AISC_VW-1:0] currentLoopSource,
	input wire logic [NUM_MA-1:0] currentLoopValid,
	input wire logic [NUM_DI-1:0][`AISC_VW-1:0] binaryInputVoltageSource,
	input wire logic [NUM_DI-1:0] binaryInputVoltageValid,
	input wire logic [NUM_RTD-1:0][`AISC_VW-1:0] temperatureSensorResistanceSource,
	input wire logic [NUM_RTD-1:0] temperatureSensorResistanceValid,
	output logic [NUM_CURVES-1:0][`AISC_VW-1:0] curveInputValue,
	output logic [NUM_CURVES-1:0][`AISC_VW-1:0] curveOutputValue,
	output logic [NUM_CURVES-1:0] curveInputRangeAlarm,
	output logic [NUM_CURVES-1:0] curveSignalLost,
	output logic [NUM_CURVES-1:0] curveUpdated,
	output logic updateStrobe
);
	localparam int TCW = $clog2(STEP_CYCLES + 1);
	localparam int PW = `AISC_VW + `AISC_SLOPE_W;

	typedef struct packed {
		logic [TCW-1:0] tickCnt;
		logic [`AISC_UPD_W-1:0] stepCnt;
		logic updStrobe;
		logic [NUM_CURVES-1:0][`AISC_VW-1:0] lastRaw;
		logic [NUM_CURVES-1:0] lost;
		logic [NUM_CURVES-1:0] filtStart;
		logic [NUM_CURVES-1:0] filtWait;
		logic [NUM_CURVES-1:0] calcPend;
		logic [NUM_CURVES-1:0] updated;
		logic [NUM_CURVES-1:0][`AISC_VW-1:0] inVal;
		logic [NUM_CURVES-1:0][`AISC_VW-1:0] outVal;
		logic [NUM_CURVES-1:0] alarm;
	} aisc_top_state_t;

	aisc_top_state_t st_reg;
	aisc_top_state_t st_next;
	logic [NUM_CURVES-1:0] filtDone;
	logic [NUM_CURVES-1:0][`AISC_VW-1:0] filtResult;
	logic tick;
	logic update;
	logic active;
	logic srcOk;
	logic [`AISC_VW-1:0] srcVal;
	logic [`AISC_VW-1:0] raw;
	logic signed [PW-1:0] prod;
	logic belowMin;
	logic aboveMax;
	int sel;

	genvar g;
	generate
		for (g = 0; g < NUM_CURVES; g++)
		begin : gen_filt
			aisc_filt_if fIf ();
			// Sample is the held raw value, registered with the start
			assign fIf.start = st_reg.filtStart[g];
			assign fIf.enable = scalingEnable && curveEnable[g] && filterEnable[g];
			assign fIf.sample = st_reg.lastRaw[g];
			assign fIf.updSteps = updateCycleSteps;
			assign fIf.tcSteps = filterTimeSteps[g];
			assign filtDone[g] = fIf.done;
			assign filtResult[g] = fIf.result;
			aisc_filter u_filter (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.fif(fIf.filt)
			);
		end
	endgenerate

	assign curveInputValue = st_reg.inVal;
	assign curveOutputValue = st_reg.outVal;
	assign curveInputRangeAlarm = st_reg.alarm;
	assign curveSignalLost = st_reg.lost;
	assign curveUpdated = st_reg.updated;
	assign updateStrobe = st_reg.updStrobe;

	always_comb
	begin
		st_next = st_reg;
		st_next.filtStart = '0;
		st_next.updated = '0;
		st_next.updStrobe = 1'b0;
		tick = 1'b0;
		update = 1'b0;
		active = 1'b0;
		srcOk = 1'b0;
		srcVal = '0;
		raw = '0;
		prod = '0;
		belowMin = 1'b0;
		aboveMax = 1'b0;
		sel = 0;

		// 5 ms step timebase
		if (st_reg.tickCnt == TCW'(STEP_CYCLES - 1))
		begin
			st_next.tickCnt = '0;
			tick = 1'b1;
		end
		else
			st_next.tickCnt = st_reg.tickCnt + TCW'(1);

		// Update cycle of N steps; zero behaves as one step
		if (tick)
		begin
			if (st_reg.stepCnt + `AISC_UPD_W'(1) >= updateCycleSteps)
			begin
				st_next.stepCnt = '0;
				update = 1'b1;
			end
			else
				st_next.stepCnt = st_reg.stepCnt + `AISC_UPD_W'(1);
		end
		st_next.updStrobe = update;

		for (int i = 0; i < NUM_CURVES; i++)
		begin
			active = scalingEnable && curveEnable[i];
			sel = int'(curveSourceSelect[i]);
			srcOk = 1'b0;
			srcVal = '0;
			// Source map: current loops, then binary input voltages, then sensors
			if (sel < NUM_MA)
			begin
				srcOk = currentLoopValid[sel];
				srcVal = currentLoopSource[sel];
			end
			else if (sel < NUM_MA + NUM_DI)
			begin
				srcOk = binaryInputVoltageValid[sel - NUM_MA];
				srcVal = binaryInputVoltageSource[sel - NUM_MA];
			end
			else if (sel < NUM_MA + NUM_DI + NUM_RTD)
			begin
				srcOk = temperatureSensorResistanceValid[sel - NUM_MA - NUM_DI];
				srcVal = temperatureSensorResistanceSource[sel - NUM_MA - NUM_DI];
			end
			else
				srcOk = 1'b0;

			if (!active)
			begin
				// Pending work is dropped so a re-enable starts clean
				st_next.filtWait[i] = 1'b0;
				st_next.calcPend[i] = 1'b0;
				st_next.alarm[i] = 1'b0;
			end
			else
			begin
				if (update)
				begin
					raw = srcOk ? srcVal : st_reg.lastRaw[i];
					st_next.lastRaw[i] = raw;
					st_next.lost[i] = !srcOk;
					if (filterEnable[i])
					begin
						st_next.filtStart[i] = 1'b1;
						st_next.filtWait[i] = 1'b1;
					end
					else
					begin
						st_next.inVal[i] = raw;
						st_next.filtWait[i] = 1'b0;
						st_next.calcPend[i] = 1'b1;
					end
				end
				if (st_reg.filtWait[i] && filtDone[i])
				begin
					st_next.inVal[i] = filtResult[i];
					st_next.filtWait[i] = 1'b0;
					st_next.calcPend[i] = 1'b1;
				end
				if (st_reg.calcPend[i])
				begin
					// Slope is fixed point with 16 fraction bits
					prod = $signed(st_reg.inVal[i]) * $signed(curveSlope[i]);
					st_next.outVal[i] = prod[`AISC_VW+`AISC_SLOPE_FRAC-1:`AISC_SLOPE_FRAC]
						+ curveOffset[i];
					st_next.updated[i] = 1'b1;
					belowMin = $signed(st_reg.inVal[i]) < $signed(inputMinimum[i]);
					aboveMax = $signed(st_reg.inVal[i]) > $signed(inputMaximum[i]);
					st_next.alarm[i] = rangeSupervisionEnable[i]
						&& (belowMin || aboveMax);
					if (!st_next.filtWait[i] && !(update && !filterEnable[i]))
						st_next.calcPend[i] = 1'b0;
				end
				// Supervision off clears at once, not at the next update
				if (!rangeSupervisionEnable[i])
					st_next.alarm[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule : aisc_top
`default_nettype wire

/* File: tb/aisc_src_model.sv */
// Source channel model: current loops, binary input voltages, sensor resistances.
// Assumes it shares sys_clk with the scaling block.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
module aisc_src_model (
	input wire logic sys_clk,
	input wire logic [`AISC_VW-1:0] loop0Value,
	input wire logic loop0Present,
	output logic [`AISC_NUM_MA-1:0][`AISC_VW-1:0] loopSrc,
	output logic [`AISC_NUM_MA-1:0] loopValid,
	output logic [`AISC_NUM_DI-1:0][`AISC_VW-1:0] diSrc,
	output logic [`AISC_NUM_DI-1:0] diValid,
	output logic [`AISC_NUM_RTD-1:0][`AISC_VW-1:0] rtdSrc,
	output logic [`AISC_NUM_RTD-1:0] rtdValid
);
	// Only loop, binary input and sensor channels exist
	initial
	begin
		for (int i = 0; i < `AISC_NUM_DI; i++) diSrc[i] = 48'h200 + i;
		for (int i = 0; i < `AISC_NUM_RTD; i++) rtdSrc[i] = 48'h300 + i;
		diValid = '1;
		rtdValid = '1;
	end
	always @(posedge sys_clk)
	begin
		for (int i = 1; i < `AISC_NUM_MA; i++) loopSrc[i] <= 48'h100 + i;
		// Loop outputs live in this process only, one driver each
		loopValid <= {{(`AISC_NUM_MA-1){1'b1}}, loop0Present};
		// Lost signal toggles so a held value cannot be faked
		loopSrc[0] <= loop0Present ? loop0Value : ~loopSrc[0];
	end
endmodule : aisc_src_model
`default_nettype wire

/* File: tb/aisc_top_assertions.sv */
// Port checker for the scaling curve top: curve 0, plus the strobe check and the all-curve master alarm check.
// Assumes curve 0 never has filtering enabled.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
module aisc_top_assertions (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic scalingEnable,
	input wire logic [9:0] curveEnable,
	input wire logic [9:0][`AISC_SEL_W-1:0] curveSourceSelect,
	input wire logic [9:0] rangeSupervisionEnable,
	input wire logic [9:0][`AISC_VW-1:0] inputMinimum,
	input wire logic [9:0][`AISC_VW-1:0] inputMaximum,
	input wire logic [9:0][`AISC_SLOPE_W-1:0] curveSlope,
	input wire logic [9:0][`AISC_VW-1:0] curveOffset,
	input wire logic [7:0][`AISC_VW-1:0] currentLoopSource,
	input wire logic [7:0] currentLoopValid,
	input wire logic [9:0][`AISC_VW-1:0] curveInputValue,
	input wire logic [9:0][`AISC_VW-1:0] curveOutputValue,
	input wire logic [9:0] curveInputRangeAlarm,
	input wire logic [9:0] curveSignalLost,
	input wire logic [9:0] curveUpdated,
	input wire logic updateStrobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic act, takeQ, lostQ, lo, hi;
	logic [`AISC_VW-1:0] srcQ;
	logic signed [79:0] prod;
	assign act = scalingEnable && curveEnable[0] && curveSourceSelect[0] == 6'h00;
	assign prod = $signed(curveInputValue[0]) * $signed(curveSlope[0]);
	assign lo = $signed(curveInputValue[0]) < $signed(inputMinimum[0]);
	assign hi = $signed(curveInputValue[0]) > $signed(inputMaximum[0]);
	always_ff @(posedge sys_clk)
	begin
		takeQ <= reset_n && act && currentLoopValid[0];
		lostQ <= reset_n && act && !currentLoopValid[0];
		srcQ <= currentLoopSource[0];
	end
	sequence s_take; updateStrobe && takeQ; endsequence
	sequence s_off3; !curveEnable[0] [*3]; endsequence
	sequence s_sup; curveUpdated[0] && rangeSupervisionEnable[0]; endsequence
	property p_strobe; updateStrobe |=> !updateStrobe; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too long");
	property p_master; !scalingEnable |=> !curveInputRangeAlarm; endproperty
	a_master: assert property (p_master) else $error("alarm while off");
	property p_curve; !curveEnable[0] |=> !curveInputRangeAlarm[0]; endproperty
	a_curve: assert property (p_curve) else $error("alarm curve off");
	property p_frozen; s_off3 |-> $stable(curveOutputValue[0]); endproperty
	a_frozen: assert property (p_frozen) else $error("output moved");
	property p_input; s_take |-> curveInputValue[0] == srcQ; endproperty
	a_input: assert property (p_input) else $error("input value");
	property p_chain; s_take |=> curveUpdated[0]; endproperty
	a_chain: assert property (p_chain) else $error("no recompute");
	property p_map;
		curveUpdated[0] |-> curveOutputValue[0] == prod[63:16] + curveOffset[0];
	endproperty
	a_map: assert property (p_map) else $error("output mapping");
	property p_low; s_sup ##0 lo |-> curveInputRangeAlarm[0]; endproperty
	a_low: assert property (p_low) else $error("below min");
	property p_high; s_sup ##0 hi |-> curveInputRangeAlarm[0]; endproperty
	a_high: assert property (p_high) else $error("above max");
	property p_in; curveUpdated[0] && !lo && !hi |-> !curveInputRangeAlarm[0]; endproperty
	a_in: assert property (p_in) else $error("alarm in limits");
	property p_lost;
		updateStrobe && lostQ |-> curveSignalLost[0] && $stable(curveInputValue[0]);
	endproperty
	a_lost: assert property (p_lost) else $error("lost not held");
endmodule : aisc_top_assertions
bind aisc_top aisc_top_assertions u_chk (.sys_clk, .reset_n, .scalingEnable, .curveEnable,
	.curveSourceSelect, .rangeSupervisionEnable, .inputMinimum, .inputMaximum, .curveSlope,
	.curveOffset, .currentLoopSource, .currentLoopValid, .curveInputValue,
	.curveOutputValue, .curveInputRangeAlarm, .curveSignalLost, .curveUpdated, .updateStrobe);
`default_nettype wire

/* File: tb/aisc_top_tb.sv */
// Self-checking bench for the scaling curve top with a source model.
// Assumes a short step so each update cycle is 100 clocks.
`timescale 1ns/100ps
`default_nettype none
`include "aisc_cfg.svh"
module aisc_top_tb;
	import aisc_pkg::*;
	logic sys_clk = 1'b0, reset_n = 1'b0, scalingEnable = 1'b0, present = 1'b1;
	logic [9:0] curveEnable = '0, filterEnable = '0, rangeEn = '0;
	logic [9:0][5:0] sel = '0;
	logic [9:0][19:0] tc = '0;
	logic [15:0] upd = 16'h0001;
	logic [9:0][47:0] minV = '0, maxV = '0, offs = '0, inV, outV;
	logic [9:0][31:0] slope = '0;
	logic [47:0] value = '0;
	logic [9:0] alarm, lost, updated;
	logic strobe;
	logic [7:0][47:0] loopS;
	logic [7:0] loopV;
	logic [19:0][47:0] diS;
	logic [19:0] diV;
	logic [15:0][47:0] rtdS;
	logic [15:0] rtdV;
	int miscompares = 0, samplesChecked = 0, cycles = 0;
	always #4 sys_clk = ~sys_clk;
	aisc_src_model u_src (.sys_clk, .loop0Value(value), .loop0Present(present),
		.loopSrc(loopS), .loopValid(loopV), .diSrc(diS), .diValid(diV), .rtdSrc(rtdS),
		.rtdValid(rtdV));
	aisc_top #(.STEP_CYCLES(100)) DUT (.sys_clk, .reset_n, .scalingEnable, .curveEnable,
		.curveSourceSelect(sel), .filterEnable, .filterTimeSteps(tc),
		.updateCycleSteps(upd), .rangeSupervisionEnable(rangeEn), .inputMinimum(minV),
		.inputMaximum(maxV), .curveSlope(slope), .curveOffset(offs),
		.currentLoopSource(loopS), .currentLoopValid(loopV),
		.binaryInputVoltageSource(diS), .binaryInputVoltageValid(diV),
		.temperatureSensorResistanceSource(rtdS), .temperatureSensorResistanceValid(rtdV),
		.curveInputValue(inV), .curveOutputValue(outV), .curveInputRangeAlarm(alarm),
		.curveSignalLost(lost), .curveUpdated(updated), .updateStrobe(strobe));
	task giveVerdict;
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : giveVerdict
	task check(input logic [47:0] seen, input logic [47:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits one update plus the slow filter path
	task waitUpd;
		int n;
		n = 0;
		@(posedge sys_clk);
		while (strobe !== 1'b1 && n < 300)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) check(48'h1, 48'h0);
		repeat (75) @(posedge sys_clk);
	endtask : waitUpd
	task t_master;
		curveEnable <= 10'h3FF;
		value <= 48'h5;
		waitUpd();
		check(inV[0], 48'h0);
		scalingEnable <= 1'b1;
		slope <= {10{32'h00020000}};
		offs[0] <= 48'h7;
		value <= 48'h1F4;
		waitUpd();
		check(inV[0], 48'h1F4);
		check(outV[0], 48'h3EF);
	endtask : t_master
	task t_sources;
		logic [5:0] codes [6];
		logic [47:0] exps [6];
		codes = '{6'h07, 6'h08, 6'h1B, 6'h1C, 6'h2B, 6'h2C};
		exps = '{48'h107, 48'h200, 48'h213, 48'h300, 48'h30F, 48'h30F};
		for (int i = 0; i < 6; i++)
		begin
			sel[0] <= codes[i];
			waitUpd();
			check(inV[0], exps[i]);
		end
		check({47'h0, lost[0]}, 48'h1);
		sel[0] <= 6'h00;
	endtask : t_sources
	task t_range;
		logic [47:0] vals [4];
		logic alms [4];
		vals = '{48'h32, 48'h96, 48'h12C, 48'h12C};
		alms = '{1'b1, 1'b0, 1'b1, 1'b0};
		slope[0] <= 32'h00010000;
		minV[0] <= 48'h64;
		maxV[0] <= 48'hC8;
		rangeEn[0] <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			value <= vals[i];
			if (i == 3) rangeEn[0] <= 1'b0;
			waitUpd();
			check({47'h0, alarm[0]}, {47'h0, alms[i]});
		end
	endtask : t_range
	task t_lost;
		present <= 1'b0;
		waitUpd();
		check(inV[0], 48'h12C);
		check({47'h0, lost[0]}, 48'h1);
		present <= 1'b1;
	endtask : t_lost
	task t_filter;
		value <= 48'h0;
		tc[1] <= 20'h00002;
		filterEnable[1] <= 1'b1;
		waitUpd();
		check(inV[1], 48'h0);
		value <= 48'h3E8;
		waitUpd();
		check(inV[1], 48'h1F4);
		waitUpd();
		check(inV[1], 48'h2EE);
		filterEnable[1] <= 1'b0;
		waitUpd();
		check(inV[1], 48'h3E8);
	endtask : t_filter
	task t_curveOff;
		curveEnable[0] <= 1'b0;
		// Above maximum, so only the disable keeps the alarm low
		rangeEn[0] <= 1'b1;
		value <= 48'h777;
		waitUpd();
		check(inV[0], 48'h3E8);
		check(outV[0], 48'h3EF);
		check({47'h0, alarm[0]}, 48'h0);
	endtask : t_curveOff
	// Hang guard well above the roughly 1900 cycles needed
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			miscompares++;
			giveVerdict();
		end
	end
	initial
	begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		check({38'h0, alarm}, 48'h0);
		t_master();
		t_sources();
		t_range();
		t_lost();
		t_filter();
		t_curveOff();
		giveVerdict();
	end
endmodule : aisc_top_tb
`default_nettype wire
